// ---- verilog/dsd_command_decoder.sv ----
// command decoder and per-channel double-buffered registers
`timescale 1ns/1ns
// Behaviour
// - low command nibble selects channel 0..15
// - no crc check for config, fault access
// - nibble 0 writes code input only
// - nibbles 1,2,3 write settings, offset, gain
// - 4 write+update one, 5 write+update all
// - nibble 6 updates addressed channel only
// - 71..76 write global registers in order
// - 70 writes config, trailing byte ignored
// - 78 code all, 79 plus update, 7C update
// - 7A settings all, 7B plus update all
// - nibbles 8..B read channel values
// - F0..F7 read globals, FF no operation
// - code and span each input plus dac
// - input A default, B for toggle
// - update copies input, clears power-down
// - update moves code and span together
// - update from command, pin pulse, toggle
// - code msb first after command byte
// - settings word field layout
// - update-only commands ignore data field
// - frame is 24 or 32 bits
// - execute only on select rising edge
// - read data returned in next frame
module dsd_command_decoder (
   input  wire logic          clk,                // system clock
   input  wire logic          rst,                // async reset, high
   input  wire logic          chip_select_load_n, // frame select, low active
   input  wire logic          sck,                // serial clock, sampled
   input  wire logic          sdi,                // serial data in
   input  wire logic          hw_update_pin_n,    // update pin, low pulse
   input  wire logic          crc_good,           // crc of current frame ok
   input  wire logic          thermal_shutdown,   // thermal status level
   output logic               sdo,                // serial data out
   output logic [255:0]       dac_code_out,       // dac code, 16 per channel
   output logic [63:0]        dac_span_out,       // dac span, 4 per channel
   output logic [15:0]        power_down_out,     // power-down per channel
   output logic [15:0]        config_out,         // configuration register
   output logic [15:0]        mux_ctrl_out,       // mux control register
   output logic [15:0]        toggle_en_out       // toggle enable register
);
   // ----------------------------------------
   // serial front end
   // ----------------------------------------
   dsd_frame_if fr ();

   dsd_spi_shift u_shift (
      .clk                (clk),
      .rst                (rst),
      .chip_select_load_n (chip_select_load_n),
      .sck                (sck),
      .sdi                (sdi),
      .sdo                (sdo),
      .fr                 (fr.shifter)
   );

   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [15:0] code_a_ff   [dsd_pkg::NUM_CH];
   logic [15:0] code_b_ff   [dsd_pkg::NUM_CH];
   logic [11:0] set_in_ff   [dsd_pkg::NUM_CH];
   logic [13:0] off_ff      [dsd_pkg::NUM_CH];
   logic [15:0] gain_ff     [dsd_pkg::NUM_CH];
   logic [15:0] dac_code_ff [dsd_pkg::NUM_CH];
   logic [3:0]  dac_span_ff [dsd_pkg::NUM_CH];
   logic [15:0] cfg_ff;
   logic [15:0] pd_ff;
   logic [15:0] absel_ff;
   logic [15:0] swtgl_ff;
   logic [15:0] tglen_ff;
   logic [15:0] mux_ff;
   logic [15:0] fault_ff;
   logic [15:0] tgl_upd_ff;
   logic        hw_update_pin_q_ff;
   logic [31:0] resp_ff;

   // ----------------------------------------
   // frame decode
   // ----------------------------------------
   wire [31:0] word_w = fr.frame_word;
   wire [7:0]  cmd_w  = word_w[dsd_pkg::CMD_MSB:dsd_pkg::CMD_LSB];
   wire [3:0]  hi_w   = cmd_w[7:4];
   wire [3:0]  ch_w   = cmd_w[3:0];
   wire [15:0] dat_w  = word_w[dsd_pkg::DAT_MSB:dsd_pkg::DAT_LSB];
   wire        long_w = (fr.frame_bits == dsd_pkg::LEN_LONG);
   wire        len_ok = long_w | (fr.frame_bits == dsd_pkg::LEN_SHORT);

   // config and fault access bypass the crc gate
   wire crc_exempt_w = (cmd_w == dsd_pkg::CMD_WR_CFG) | (cmd_w == dsd_pkg::CMD_RD_CFG) |
                       (cmd_w == dsd_pkg::CMD_WR_FAULT) | (cmd_w == dsd_pkg::CMD_RD_FAULT);
   wire crc_en_w     = cfg_ff[dsd_pkg::CFG_CRC_EN_BIT];
   wire crc_pass_w   = ~crc_en_w | crc_exempt_w | (long_w & crc_good);
   wire exec_w       = fr.frame_valid & len_ok & crc_pass_w;

   wire wr_code_one_w = (hi_w == dsd_pkg::NIB_WR_CODE) | (hi_w == dsd_pkg::NIB_WR_UPD) |
                        (hi_w == dsd_pkg::NIB_WR_UPD_ALL);
   wire wr_set_one_w  = (hi_w == dsd_pkg::NIB_WR_SET);
   wire wr_off_one_w  = (hi_w == dsd_pkg::NIB_WR_OFF);
   wire wr_gain_one_w = (hi_w == dsd_pkg::NIB_WR_GAIN);
   wire upd_one_w     = (hi_w == dsd_pkg::NIB_WR_UPD) | (hi_w == dsd_pkg::NIB_UPD);
   wire wr_code_all_w = (cmd_w == dsd_pkg::CMD_CODE_ALL) | (cmd_w == dsd_pkg::CMD_CODE_UPD_ALL);
   wire wr_set_all_w  = (cmd_w == dsd_pkg::CMD_SET_ALL) | (cmd_w == dsd_pkg::CMD_SET_UPD_ALL);
   // update-only commands never touch input registers
   wire upd_all_w     = (hi_w == dsd_pkg::NIB_WR_UPD_ALL) | (cmd_w == dsd_pkg::CMD_CODE_UPD_ALL) |
                        (cmd_w == dsd_pkg::CMD_SET_UPD_ALL) | (cmd_w == dsd_pkg::CMD_UPD_ALL);

   wire wr_cfg_w   = exec_w & (cmd_w == dsd_pkg::CMD_WR_CFG);
   wire wr_pd_w    = exec_w & (cmd_w == dsd_pkg::CMD_WR_PD);
   wire wr_absel_w = exec_w & (cmd_w == dsd_pkg::CMD_WR_ABSEL);
   wire wr_swtgl_w = exec_w & (cmd_w == dsd_pkg::CMD_WR_SWTGL);
   wire wr_tglen_w = exec_w & (cmd_w == dsd_pkg::CMD_WR_TGLEN);
   wire wr_mux_w   = exec_w & (cmd_w == dsd_pkg::CMD_WR_MUX);
   wire wr_fault_w = exec_w & (cmd_w == dsd_pkg::CMD_WR_FAULT);

   wire is_rd_ch_w  = (hi_w >= dsd_pkg::NIB_RD_CODE) & (hi_w <= dsd_pkg::NIB_RD_GAIN);
   wire is_rd_gl_w  = (cmd_w >= dsd_pkg::CMD_RD_CFG) & (cmd_w <= dsd_pkg::CMD_RD_THERM);
   // anything outside the tables decodes to no strobe at all
   wire known_w     = (hi_w <= dsd_pkg::NIB_UPD) | is_rd_ch_w | is_rd_gl_w |
                      ((cmd_w >= dsd_pkg::CMD_WR_CFG) & (cmd_w <= dsd_pkg::CMD_WR_FAULT)) |
                      ((cmd_w >= dsd_pkg::CMD_CODE_ALL) & (cmd_w <= dsd_pkg::CMD_UPD_ALL)) |
                      (cmd_w == dsd_pkg::CMD_NOP);
   wire is_read_w   = is_rd_ch_w | is_rd_gl_w;

   // pin falling edge updates every channel
   wire hw_update_pin_fall_w = hw_update_pin_q_ff & ~hw_update_pin_n;

   // ----------------------------------------
   // per-channel registers
   // ----------------------------------------
   logic [15:0] wr_code_v;
   logic [15:0] wr_set_v;
   logic [15:0] wr_off_v;
   logic [15:0] wr_gain_v;
   logic [15:0] upd_v;
   logic [15:0] use_b_v;

   for (genvar i = 0; i < dsd_pkg::NUM_CH; i++) begin : g_ch
      wire sel_w = (ch_w == 4'(i));
      assign wr_code_v[i] = exec_w & ((wr_code_one_w & sel_w) | wr_code_all_w);
      assign wr_set_v[i]  = exec_w & ((wr_set_one_w & sel_w) | wr_set_all_w);
      assign wr_off_v[i]  = exec_w & wr_off_one_w & sel_w;
      assign wr_gain_v[i] = exec_w & wr_gain_one_w & sel_w;
      assign upd_v[i]     = (exec_w & ((upd_one_w & sel_w) | upd_all_w)) |
                            hw_update_pin_fall_w | tgl_upd_ff[i];
      // B only feeds the dac while toggling
      assign use_b_v[i]   = tglen_ff[i] & swtgl_ff[i];
      // same-frame write reaches the dac together with its update
      wire [15:0] code_a_w = (wr_code_v[i] & ~absel_ff[i]) ? dat_w : code_a_ff[i];
      wire [15:0] code_b_w = (wr_code_v[i] & absel_ff[i]) ? dat_w : code_b_ff[i];
      wire [11:0] set_w    = wr_set_v[i] ? dat_w[dsd_pkg::SET_W-1:dsd_pkg::SET_LSB] :
                             set_in_ff[i];

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            code_a_ff[i] <= dsd_pkg::RST_CODE;
            code_b_ff[i] <= dsd_pkg::RST_CODE;
         end else if (wr_code_v[i]) begin
            if (absel_ff[i]) begin
               code_b_ff[i] <= dat_w;
            end else begin
               code_a_ff[i] <= dat_w;
            end
         end
      end

      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            set_in_ff[i] <= dsd_pkg::RST_SET;
            off_ff[i]    <= dsd_pkg::RST_OFF;
            gain_ff[i]   <= dsd_pkg::RST_GAIN;
         end else begin
            if (wr_set_v[i]) set_in_ff[i] <= dat_w[dsd_pkg::SET_W-1:dsd_pkg::SET_LSB];
            if (wr_off_v[i]) off_ff[i] <= dat_w[15:dsd_pkg::OFF_LSB];
            if (wr_gain_v[i]) gain_ff[i] <= dat_w;
         end
      end

      // active registers: code and span always move together
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            dac_code_ff[i] <= dsd_pkg::RST_CODE;
            dac_span_ff[i] <= dsd_pkg::RST_SPAN;
         end else if (upd_v[i]) begin
            dac_code_ff[i] <= use_b_v[i] ? code_b_w : code_a_w;
            dac_span_ff[i] <= set_w[dsd_pkg::SPAN_W-1:dsd_pkg::SPAN_LSB];
         end
      end

      assign dac_code_out[i*16 +: 16] = dac_code_ff[i];
      assign dac_span_out[i*4 +: 4]   = dac_span_ff[i];
   end

   // ----------------------------------------
   // global registers
   // ----------------------------------------
   // an update wakes a powered-down channel
   wire [15:0] nxt_pd_ff    = (wr_pd_w ? dat_w : pd_ff) & ~upd_v;
   wire [15:0] nxt_tgl_upd  = wr_swtgl_w ? tglen_ff : 16'h0000;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff     <= dsd_pkg::RST_REG;
         pd_ff      <= dsd_pkg::RST_REG;
         absel_ff   <= dsd_pkg::RST_REG;
         swtgl_ff   <= dsd_pkg::RST_REG;
         tglen_ff   <= dsd_pkg::RST_REG;
         mux_ff     <= dsd_pkg::RST_REG;
         fault_ff   <= dsd_pkg::RST_REG;
         tgl_upd_ff <= dsd_pkg::RST_REG;
         hw_update_pin_q_ff  <= 1'b1;
      end else begin
         if (wr_cfg_w) cfg_ff <= dat_w;
         pd_ff <= nxt_pd_ff;
         if (wr_absel_w) absel_ff <= dat_w;
         if (wr_swtgl_w) swtgl_ff <= dat_w;
         if (wr_tglen_w) tglen_ff <= dat_w;
         if (wr_mux_w) mux_ff <= dat_w;
         if (wr_fault_w) fault_ff <= dat_w;
         tgl_upd_ff <= nxt_tgl_upd;
         hw_update_pin_q_ff  <= hw_update_pin_n;
      end
   end

   // ----------------------------------------
   // readback
   // ----------------------------------------
   wire [15:0] rd_data_w =
      (hi_w == dsd_pkg::NIB_RD_CODE)     ? dac_code_ff[ch_w] :
      (hi_w == dsd_pkg::NIB_RD_SET)      ? {4'h0, set_in_ff[ch_w]} :
      (hi_w == dsd_pkg::NIB_RD_OFF)      ? {off_ff[ch_w], 2'b00} :
      (hi_w == dsd_pkg::NIB_RD_GAIN)     ? gain_ff[ch_w] :
      (cmd_w == dsd_pkg::CMD_RD_CFG)     ? cfg_ff :
      (cmd_w == dsd_pkg::CMD_RD_PD)      ? pd_ff :
      (cmd_w == dsd_pkg::CMD_RD_ABSEL)   ? absel_ff :
      (cmd_w == dsd_pkg::CMD_RD_SWTGL)   ? swtgl_ff :
      (cmd_w == dsd_pkg::CMD_RD_TGLEN)   ? tglen_ff :
      (cmd_w == dsd_pkg::CMD_RD_MUX)     ? mux_ff :
      (cmd_w == dsd_pkg::CMD_RD_FAULT)   ? fault_ff :
      (cmd_w == dsd_pkg::CMD_RD_THERM)   ? {15'h0000, thermal_shutdown} : 16'h0000;

   // reads return data, writes echo the word; short frames carry no echo
   wire [31:0] rd_word_w = long_w ? {cmd_w, rd_data_w, 8'h00} : {8'h00, rd_data_w, 8'h00};
   wire [31:0] nxt_resp  = ~exec_w ? dsd_pkg::RST_WORD :
                           is_read_w ? rd_word_w :
                           long_w ? word_w : dsd_pkg::RST_WORD;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         resp_ff <= dsd_pkg::RST_WORD;
      end else if (fr.frame_valid) begin
         resp_ff <= nxt_resp;
      end
   end

   assign fr.resp_word   = resp_ff;
   assign power_down_out = pd_ff;
   assign config_out     = cfg_ff;
   assign mux_ctrl_out   = mux_ff;
   assign toggle_en_out  = tglen_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   code_write_a: assert property (
      (exec_w && hi_w == dsd_pkg::NIB_WR_CODE && ch_w == 4'h0 && !absel_ff[0] && !hw_update_pin_fall_w)
      |=> (code_a_ff[0] == $past(dat_w)) && $stable(dac_code_ff[0]))
      else $error("code write to channel 0 wrong");

   upd_one_a: assert property (
      (exec_w && hi_w == dsd_pkg::NIB_UPD && ch_w == 4'h3 && !use_b_v[3])
      |=> (dac_code_ff[3] == $past(code_a_ff[3])) && (dac_span_ff[3] == $past(set_in_ff[3][3:0])))
      else $error("single update did not copy inputs");

   code_all_a: assert property (
      (exec_w && cmd_w == dsd_pkg::CMD_CODE_ALL && !absel_ff[0] && !absel_ff[15])
      |=> (code_a_ff[0] == $past(dat_w)) && (code_a_ff[15] == $past(dat_w)))
      else $error("broadcast code write missed a channel");

   pd_wake_a: assert property (
      (upd_v != 16'h0000) |=> ((pd_ff & $past(upd_v)) == 16'h0000))
      else $error("update left channel powered down");

   pin_update_a: assert property (
      $fell(hw_update_pin_n) |=> (dac_span_ff[7] == $past(set_in_ff[7][3:0])))
      else $error("pin pulse did not update");

   crc_skip_a: assert property (
      (fr.frame_valid && long_w && cmd_w == dsd_pkg::CMD_WR_CFG && crc_en_w && !crc_good)
      |=> (cfg_ff == $past(dat_w)))
      else $error("config write blocked by crc");

   frame_only_a: assert property (
      !fr.frame_valid |=> $stable(cfg_ff) && $stable(mux_ff) && $stable(fault_ff))
      else $error("register changed outside a frame end");

   unknown_cmd_a: assert property (
      (fr.frame_valid && !known_w)
      |=> $stable(cfg_ff) && $stable(absel_ff) && $stable(code_a_ff[0]) ##1 $stable(mux_ff))
      else $error("unlisted command changed state");

   read_resp_a: assert property (
      (exec_w && long_w && cmd_w == dsd_pkg::CMD_RD_CFG)
      |=> (resp_ff == {dsd_pkg::CMD_RD_CFG, $past(cfg_ff), 8'h00}))
      else $error("config readback word wrong");
endmodule

// ---- shared/dsd_pkg.sv ----
// constants for the dac command decoder
package dsd_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CH = 16;
   localparam int CH_W   = 4;
   localparam int DAT_W  = 16;
   localparam int WORD_W = 32;
   localparam int CNT_W  = 6;
   localparam int SET_W  = 12;
   localparam int OFF_W  = 14;
   localparam int SPAN_W = 4;

   // ----------------------------------------
   // frame layout
   // ----------------------------------------
   localparam logic [5:0] LEN_SHORT = 6'h18;
   localparam logic [5:0] LEN_LONG  = 6'h20;
   localparam logic [5:0] CNT_MAX   = 6'h3F;
   localparam int CMD_MSB = 31;
   localparam int CMD_LSB = 24;
   localparam int DAT_MSB = 23;
   localparam int DAT_LSB = 8;

   // ----------------------------------------
   // command upper nibbles
   // ----------------------------------------
   localparam logic [3:0] NIB_WR_CODE    = 4'h0;
   localparam logic [3:0] NIB_WR_SET     = 4'h1;
   localparam logic [3:0] NIB_WR_OFF     = 4'h2;
   localparam logic [3:0] NIB_WR_GAIN    = 4'h3;
   localparam logic [3:0] NIB_WR_UPD     = 4'h4;
   localparam logic [3:0] NIB_WR_UPD_ALL = 4'h5;
   localparam logic [3:0] NIB_UPD        = 4'h6;
   localparam logic [3:0] NIB_RD_CODE    = 4'h8;
   localparam logic [3:0] NIB_RD_SET     = 4'h9;
   localparam logic [3:0] NIB_RD_OFF     = 4'hA;
   localparam logic [3:0] NIB_RD_GAIN    = 4'hB;

   // ----------------------------------------
   // whole command bytes
   // ----------------------------------------
   localparam logic [7:0] CMD_WR_CFG       = 8'h70;
   localparam logic [7:0] CMD_WR_PD        = 8'h71;
   localparam logic [7:0] CMD_WR_ABSEL     = 8'h72;
   localparam logic [7:0] CMD_WR_SWTGL     = 8'h73;
   localparam logic [7:0] CMD_WR_TGLEN     = 8'h74;
   localparam logic [7:0] CMD_WR_MUX       = 8'h75;
   localparam logic [7:0] CMD_WR_FAULT     = 8'h76;
   localparam logic [7:0] CMD_CODE_ALL     = 8'h78;
   localparam logic [7:0] CMD_CODE_UPD_ALL = 8'h79;
   localparam logic [7:0] CMD_SET_ALL      = 8'h7A;
   localparam logic [7:0] CMD_SET_UPD_ALL  = 8'h7B;
   localparam logic [7:0] CMD_UPD_ALL      = 8'h7C;
   localparam logic [7:0] CMD_RD_CFG       = 8'hF0;
   localparam logic [7:0] CMD_RD_PD        = 8'hF1;
   localparam logic [7:0] CMD_RD_ABSEL     = 8'hF2;
   localparam logic [7:0] CMD_RD_SWTGL     = 8'hF3;
   localparam logic [7:0] CMD_RD_TGLEN     = 8'hF4;
   localparam logic [7:0] CMD_RD_MUX       = 8'hF5;
   localparam logic [7:0] CMD_RD_FAULT     = 8'hF6;
   localparam logic [7:0] CMD_RD_THERM     = 8'hF7;
   localparam logic [7:0] CMD_NOP          = 8'hFF;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SET_LSB        = 0;
   localparam int SPAN_LSB       = 0;
   localparam int OFF_LSB        = 2;
   localparam int CFG_CRC_EN_BIT = 0;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [15:0] RST_CODE = 16'h0000;
   localparam logic [11:0] RST_SET  = 12'h000;
   localparam logic [13:0] RST_OFF  = 14'h0000;
   localparam logic [15:0] RST_GAIN = 16'h0000;
   localparam logic [3:0]  RST_SPAN = 4'h0;
   localparam logic [15:0] RST_REG  = 16'h0000;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// ---- shared/dsd_frame_if.sv ----
// frame hand-over between serial shifter and decoder
`timescale 1ns/1ns
interface dsd_frame_if;
   logic        frame_valid;
   logic [31:0] frame_word;
   logic [5:0]  frame_bits;
   logic [31:0] resp_word;

   modport shifter (
      output frame_valid,
      output frame_word,
      output frame_bits,
      input  resp_word
   );
   modport decoder (
      input  frame_valid,
      input  frame_word,
      input  frame_bits,
      output resp_word
   );
endinterface

// ---- verilog/dsd_spi_shift.sv ----
// serial shifter: collects one frame, plays back the response word
`timescale 1ns/1ns
module dsd_spi_shift (
   input  wire logic       clk,                // system clock
   input  wire logic       rst,                // async reset, high
   input  wire logic       chip_select_load_n, // frame select, low active
   input  wire logic       sck,                // serial clock, sampled
   input  wire logic       sdi,                // serial data in
   output logic            sdo,                // serial data out
   dsd_frame_if.shifter    fr                  // frame to decoder
);
   logic                       cs_q_ff;
   logic                       sck_q_ff;
   logic [dsd_pkg::WORD_W-1:0] in_ff;
   logic [dsd_pkg::WORD_W-1:0] out_ff;
   logic [dsd_pkg::CNT_W-1:0]  cnt_ff;
   logic                       sdo_ff;
   logic                       valid_ff;
   logic [dsd_pkg::WORD_W-1:0] word_ff;
   logic [dsd_pkg::CNT_W-1:0]  bits_ff;

   wire cs_fall_w  = cs_q_ff & ~chip_select_load_n;
   wire cs_rise_w  = ~cs_q_ff & chip_select_load_n;
   wire sck_rise_w = ~chip_select_load_n & ~sck_q_ff & sck;
   wire sck_fall_w = ~chip_select_load_n & sck_q_ff & ~sck;
   // 24-bit frames are left-aligned so the decoder sees one layout
   wire [31:0] word_w = (cnt_ff == dsd_pkg::LEN_SHORT) ? {in_ff[23:0], 8'h00} : in_ff;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_q_ff  <= 1'b1;
         sck_q_ff <= 1'b0;
      end else begin
         cs_q_ff  <= chip_select_load_n;
         sck_q_ff <= sck;
      end
   end

   // msb first capture on rising serial edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_ff  <= dsd_pkg::RST_WORD;
         cnt_ff <= '0;
      end else if (cs_fall_w) begin
         cnt_ff <= '0;
      end else if (sck_rise_w) begin
         in_ff  <= {in_ff[30:0], sdi};
         cnt_ff <= (cnt_ff == dsd_pkg::CNT_MAX) ? cnt_ff : cnt_ff + 6'h01;
      end
   end

   // response shifts out on falling serial edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ff <= dsd_pkg::RST_WORD;
         sdo_ff <= 1'b0;
      end else if (cs_fall_w) begin
         out_ff <= fr.resp_word;
         sdo_ff <= fr.resp_word[31];
      end else if (sck_fall_w) begin
         out_ff <= {out_ff[30:0], 1'b0};
         sdo_ff <= out_ff[30];
      end else if (cs_rise_w) begin
         sdo_ff <= 1'b0;
      end
   end

   // frame handed over only at the end of select
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         valid_ff <= 1'b0;
         word_ff  <= dsd_pkg::RST_WORD;
         bits_ff  <= '0;
      end else begin
         valid_ff <= cs_rise_w;
         if (cs_rise_w) begin
            word_ff <= word_w;
            bits_ff <= cnt_ff;
         end
      end
   end

   assign sdo            = sdo_ff;
   assign fr.frame_valid = valid_ff;
   assign fr.frame_word  = word_ff;
   assign fr.frame_bits  = bits_ff;
endmodule

// ---- verification/dsd_spi_host.sv ----
// serial host model driving frames into the decoder
`timescale 1ns/1ns
module dsd_spi_host (
   input  wire logic clk,  // system clock
   output logic      cs_n, // frame select, low active
   output logic      sck,  // serial clock, idle low
   output logic      sdi,  // serial data out to device
   input  wire logic sdo,  // serial data from device
   output logic [31:0] rx  // bits collected this frame
);
   initial begin
      cs_n = 1'b1;
      sck  = 1'b0;
      sdi  = 1'b0;
   end
   // ----------------------------------------
   // one frame of n bits, msb first
   // ----------------------------------------
   task automatic frame(input logic [31:0] w, input int n);
      @(negedge clk);
      cs_n = 1'b0;
      rx   = '0;
      for (int i = 31; i > 31 - n; i--) begin
         sdi = w[i];
         repeat (3) @(negedge clk);
         sck = 1'b1;
         rx  = {rx[30:0], sdo};
         repeat (3) @(negedge clk);
         sck = 1'b0;
      end
      repeat (3) @(negedge clk);
      cs_n = 1'b1;
      sdi  = ~sdi;
      repeat (4) @(negedge clk);
   endtask
endmodule

// ---- verification/dsd_command_decoder_tb_top.sv ----
// testbench for the dac command decoder
`timescale 1ns/1ns
module dsd_command_decoder_tb_top;
   logic clk = 1'b0, rst, cs_n, sck, sdi, hw_n, crc_good, therm, sdo;
   logic [255:0] code, dac_m;
   logic [63:0]  span, span_m;
   logic [15:0]  pd, cfg, mux, tgl, pd_m, cfg_m, mux_m, tgl_m, d;
   logic [15:0]  in_m [16];
   logic [415:0] exp_q [$];
   logic [31:0]  rx, resp_m, rx_e;
   int           fail_count, comparisons, seed;
   always #5 clk = ~clk;
   dsd_spi_host dsd_spi_host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
      .rx(rx));
   dsd_command_decoder dsd_command_decoder_i (.clk(clk), .rst(rst),
      .chip_select_load_n(cs_n), .sck(sck), .sdi(sdi), .hw_update_pin_n(hw_n),
      .crc_good(crc_good), .thermal_shutdown(therm), .sdo(sdo), .dac_code_out(code),
      .dac_span_out(span), .power_down_out(pd), .config_out(cfg),
      .mux_ctrl_out(mux), .toggle_en_out(tgl));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input logic [415:0] seen, input logic [415:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   // for reads dat carries the expected read data (field is don't care)
   task automatic send(input logic [7:0] c, input logic [15:0] dat, input int n);
      logic rd;
      rd   = (c[7:6] == 2'b10) || (c[7:3] == 5'b11110);
      rx_e = resp_m >> (32 - n);
      exp_q.push_back({dac_m, span_m, pd_m, cfg_m, mux_m, tgl_m, rx_e});
      resp_m = (n == 32) ? {c, dat, 8'h00} : (rd ? {8'h00, dat, 8'h00} : 32'h0000_0000);
      dsd_spi_host_i.frame({c, dat, 8'h00}, n);
   endtask
   function automatic void upd(input int ch);
      dac_m[16*ch +: 16] = in_m[ch];
      pd_m[ch] = 1'b0;
   endfunction
   task automatic test_done;
      if (fail_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // result monitor
   // ----------------------------------------
   always @(posedge cs_n or negedge hw_n) begin
      repeat (3) @(negedge clk);
      if (exp_q.size() > 0) check({code, span, pd, cfg, mux, tgl, rx}, exp_q.pop_front());
   end
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 19413;
      rst = 1'b1; hw_n = 1'b1; crc_good = 1'b0; therm = 1'b0;
      dac_m = '0; pd_m = '0; cfg_m = '0;
      span_m = '0; mux_m = '0; tgl_m = '0; resp_m = '0; rx_e = '0;
      foreach (in_m[i]) in_m[i] = '0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      for (int ch = 0; ch < 16; ch++) begin
         d = $random(seed);
         in_m[ch] = d;
         send({4'h0, ch[3:0]}, d, 24);
      end
      upd(3);
      send(8'h63, $random(seed), 24);
      d = $random(seed); in_m[9] = d; upd(9);
      send(8'h49, d, 32);
      pd_m = 16'hFFFF;
      send(8'h71, 16'hFFFF, 24);
      d = $random(seed); in_m[0] = d;
      for (int i = 0; i < 16; i++) upd(i);
      send(8'h50, d, 24);
      d = $random(seed); in_m[1] = d;
      send(8'h01, d, 24);
      for (int i = 0; i < 16; i++) upd(i);
      exp_q.push_back({dac_m, span_m, pd_m, cfg_m, mux_m, tgl_m, rx_e});
      hw_n = 1'b0;
      repeat (2) @(negedge clk);
      hw_n = 1'b1;
      repeat (6) @(negedge clk);
      d = $random(seed);
      for (int i = 0; i < 16; i++) begin in_m[i] = d; upd(i); end
      send(8'h79, d, 24);
      send(8'h7D, $random(seed), 24);
      d = $random(seed); mux_m = d;
      send(8'h75, d, 24);
      d = $random(seed); tgl_m = d;
      send(8'h74, d, 32);
      d = $random(seed);
      for (int i = 0; i < 16; i++) begin span_m[4*i +: 4] = d[3:0]; upd(i); end
      send(8'h7B, d, 24);
      send(8'hF5, mux_m, 32);
      send(8'h92, {4'h0, d[11:0]}, 24);
      cfg_m = 16'h0001;
      send(8'h70, 16'h0001, 24);
      send(8'h71, 16'h00FF, 24);
      cfg_m = 16'h0000;
      send(8'h70, 16'h0000, 24);
      repeat (10) @(negedge clk);
      test_done();
   end
endmodule
